// file: logic/pbu_match.v
`timescale 1ns/10ps
`include "pbu_consts.vh"


module pbu_match #(
	parameter NUM_CODE        = 6,
	parameter LITERAL_COMPARATOR_COUNT         = 2,
	parameter REMAP_SUPPORTED = 1,
	parameter MAIN_EXT        = 1,
	parameter SECURITY_EXT    = 0,
	parameter VECTOR_AS_DATA  = 1,
	parameter PRIO_W          = 8
) (
	input  wire                     clk,
	input  wire                     rstn,
	// Control writes
	input  wire                     ctrl_wr,
	input  wire                     ctrl_enable,
	input  wire                     remap_wr,
	input  wire [31:0]              remap_base_in,
	input  wire                     code_cfg_wr,
	input  wire [`PBU_IDX_W-1:0]    code_cfg_idx,
	input  wire [31:0]              code_cfg_addr,
	input  wire                     code_cfg_enable,
	input  wire                     code_cfg_remap,
	input  wire                     code_cfg_both,
	input  wire                     lit_cfg_wr,
	input  wire [`PBU_IDX_W-1:0]    lit_cfg_idx,
	input  wire [31:0]              lit_cfg_addr,
	input  wire                     lit_cfg_enable,
	// Status readback
	output wire                     global_enable,
	output wire [`PBU_CNT_W-1:0]    code_comparator_count,
	output wire [`PBU_CNT_W-1:0]    literal_comparator_count,
	output wire                     remap_supported_flag,
	output wire [31:0]              remap_base,
	input  wire [`PBU_IDX_W-1:0]    code_rd_idx,
	output reg  [31:0]              code_rd_addr,
	output reg                      code_rd_enable,
	output reg                      code_rd_remap,
	output reg                      code_rd_both,
	input  wire [`PBU_IDX_W-1:0]    lit_rd_idx,
	output reg  [31:0]              lit_rd_addr,
	output reg                      lit_rd_enable,
	// Instruction fetch path
	input  wire                     fetch_valid,
	input  wire [31:0]              fetch_addr,
	input  wire                     fetch_from_dap,
	input  wire                     fetch_secure,
	output wire                     fetch_redirect,
	output wire [31:0]              fetch_addr_out,
	output wire [31:0]              fetch_pc_value,
	output wire                     bkpt_match,
	output wire                     bkpt_halt,
	output wire                     bkpt_monitor,
	output wire                     bkpt_discard,
	// Debug state from the core
	input  wire                     halting_auth_allowed,
	input  wire                     halting_debug_enable,
	input  wire                     halted_status,
	input  wire                     secure_debug_flag,
	input  wire                     monitor_enable,
	input  wire                     secure_monitor_enable,
	input  wire [PRIO_W-1:0]        monitor_priority,
	input  wire [PRIO_W-1:0]        current_priority,
	// Data path
	input  wire                     data_valid,
	input  wire [31:0]              data_addr,
	input  wire                     data_write,
	input  wire [1:0]               data_size,
	input  wire                     data_stacking,
	input  wire                     data_vector,
	input  wire                     data_from_dap,
	output wire                     data_redirect,
	output wire [31:0]              data_addr_out,
	output wire [31:0]              data_check_addr,
	// Last breakpoint record
	output reg                      last_bkpt_valid_reg,
	output reg  [31:0]              last_bkpt_addr_reg,
	output reg  [2:0]               last_bkpt_result_reg
);

	// Remapping is impossible without main ext or with security ext
	localparam REMAP_OK = (REMAP_SUPPORTED != 0) && (MAIN_EXT != 0)
		&& (SECURITY_EXT == 0);
	localparam [`PBU_CNT_W-1:0] CODE_CNT = NUM_CODE[`PBU_CNT_W-1:0];
	localparam [`PBU_CNT_W-1:0] LIT_CNT  = REMAP_OK
		? LITERAL_COMPARATOR_COUNT[`PBU_CNT_W-1:0] : {`PBU_CNT_W{1'b0}};
	localparam [2:0] RES_HALT    = 3'h1;
	localparam [2:0] RES_MONITOR = 3'h2;
	localparam [2:0] RES_DISCARD = 3'h4;

	reg                     global_enable_reg;
	reg  [`PBU_REMAP_W-1:0] remap_base_reg;
	reg                     global_enable_next;
	reg  [`PBU_REMAP_W-1:0] remap_base_next;
	reg                     last_bkpt_valid_next;
	reg  [31:0]             last_bkpt_addr_next;
	reg  [2:0]              last_bkpt_result_next;

	wire [NUM_CODE-1:0]     code_bp_hit;
	wire [NUM_CODE-1:0]     code_remap_hit;
	wire [NUM_CODE*32-1:0]  code_addr_all;
	wire [NUM_CODE-1:0]     code_en_all;
	wire [NUM_CODE-1:0]     code_remap_all;
	wire [NUM_CODE-1:0]     code_both_all;
	wire [LITERAL_COMPARATOR_COUNT-1:0]      lit_hit;
	wire [LITERAL_COMPARATOR_COUNT*32-1:0]   lit_addr_all;
	wire [LITERAL_COMPARATOR_COUNT-1:0]      lit_en_all;

	wire                    fetch_ok;
	wire                    read_ok;
	wire                    unaligned;
	wire [31:0]             base_addr;
	wire [31:0]             fetch_slot;
	wire [31:0]             data_slot;
	wire                    halt_ok;
	wire                    mon_ok;
	reg  [`PBU_SLOT_W-1:0]  fetch_idx;
	reg  [`PBU_SLOT_W-1:0]  lit_idx;
	integer                 i;
	integer                 j;
	integer                 k;
	integer                 m;

	// Control register next values
	always @* begin
		global_enable_next = global_enable_reg;
		remap_base_next    = remap_base_reg;
		if (ctrl_wr) begin
			global_enable_next = ctrl_enable;
		end
		if (remap_wr && REMAP_OK) begin
			remap_base_next = remap_base_in[31:`PBU_REMAP_LSB];
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			global_enable_reg <= `PBU_GLOBAL_EN_RST;
			remap_base_reg    <= `PBU_REMAP_RST;
		end else begin
			global_enable_reg <= global_enable_next;
			remap_base_reg    <= remap_base_next;
		end
	end

	assign global_enable            = global_enable_reg;
	assign code_comparator_count    = CODE_CNT;
	assign literal_comparator_count = LIT_CNT;
	assign remap_supported_flag     = REMAP_OK ? 1'b1 : 1'b0;
	assign base_addr  = {remap_base_reg, {`PBU_REMAP_LSB{1'b0}}};
	assign remap_base = base_addr;

	// Debug port traffic never reaches the comparators
	assign fetch_ok = fetch_valid & ~fetch_from_dap;
	// Unaligned halfword and word reads are left unredirected
	assign unaligned = ((data_size == `PBU_SIZE_WORD)
		&& (data_addr[1:0] != 2'b00))
		|| ((data_size == `PBU_SIZE_HALF) && data_addr[0]);
	// Stacking traffic is ordinary data, vector reads never fetches
	assign read_ok = data_valid & ~data_write & ~data_from_dap
		& ~unaligned & (~data_vector | (VECTOR_AS_DATA != 0))
		& (data_stacking | 1'b1);

	genvar g;
	generate
		for (g = 0; g < NUM_CODE; g = g + 1) begin : g_code
			pbu_code_cmp #(
				.REMAP_OK (REMAP_OK ? 1 : 0)
			) u_code (
				.clk           (clk),
				.rstn          (rstn),
				.cfg_wr        (code_cfg_wr && (code_cfg_idx == g)),
				.cfg_addr      (code_cfg_addr),
				.cfg_enable    (code_cfg_enable),
				.cfg_remap     (code_cfg_remap),
				.cfg_both      (code_cfg_both),
				.global_enable (global_enable_reg),
				.fetch_valid   (fetch_ok),
				.fetch_addr    (fetch_addr),
				.bp_hit        (code_bp_hit[g]),
				.remap_hit     (code_remap_hit[g]),
				.cmp_addr      (code_addr_all[g*32 +: 32]),
				.cmp_enable    (code_en_all[g]),
				.cmp_remap     (code_remap_all[g]),
				.cmp_both      (code_both_all[g])
			);
		end
		for (g = 0; g < LITERAL_COMPARATOR_COUNT; g = g + 1) begin : g_lit
			if (REMAP_OK) begin : g_on
				pbu_lit_cmp u_lit (
					.clk           (clk),
					.rstn          (rstn),
					.cfg_wr        (lit_cfg_wr && (lit_cfg_idx == g)),
					.cfg_addr      (lit_cfg_addr),
					.cfg_enable    (lit_cfg_enable),
					.global_enable (global_enable_reg),
					.rd_valid      (read_ok),
					.rd_addr       (data_addr),
					.hit           (lit_hit[g]),
					.cmp_addr      (lit_addr_all[g*32 +: 32]),
					.cmp_enable    (lit_en_all[g])
				);
			end else begin : g_off
				assign lit_hit[g]               = 1'b0;
				assign lit_addr_all[g*32 +: 32] = 32'h0000_0000;
				assign lit_en_all[g]            = 1'b0;
			end
		end
	endgenerate

	// Lowest numbered hit wins among overlapping remaps
	always @* begin
		fetch_idx = {`PBU_SLOT_W{1'b0}};
		for (i = NUM_CODE - 1; i >= 0; i = i - 1) begin
			if (code_remap_hit[i]) begin
				fetch_idx = i[`PBU_SLOT_W-1:0];
			end
		end
	end

	// Literal comparators take slot numbers after the code ones
	always @* begin
		lit_idx = {`PBU_SLOT_W{1'b0}};
		for (j = LITERAL_COMPARATOR_COUNT - 1; j >= 0; j = j - 1) begin
			if (lit_hit[j]) begin
				lit_idx = j[`PBU_SLOT_W-1:0] + CODE_CNT;
			end
		end
	end

	assign fetch_slot = base_addr
		+ {{(30 - `PBU_SLOT_W){1'b0}}, fetch_idx, 2'b00};
	assign data_slot  = base_addr
		+ {{(30 - `PBU_SLOT_W){1'b0}}, lit_idx, 2'b00};

	// A breakpoint on the same fetch overrides a remap
	assign bkpt_match     = |code_bp_hit;
	assign fetch_redirect = (|code_remap_hit) & ~bkpt_match;
	assign fetch_addr_out = fetch_redirect
		? {fetch_slot[31:2], fetch_addr[1:0]} : fetch_addr;
	assign fetch_pc_value = fetch_addr;

	assign data_redirect  = |lit_hit;
	// Byte lane kept so each read size picks its item
	assign data_addr_out  = data_redirect
		? {data_slot[31:2], data_addr[1:0]} : data_addr;
	assign data_check_addr = data_addr;

	assign halt_ok = halting_auth_allowed & halting_debug_enable
		& ~halted_status
		& ((SECURITY_EXT == 0) | ~fetch_secure | secure_debug_flag);
	// Lower number means higher priority
	assign mon_ok = (MAIN_EXT != 0) & monitor_enable & halted_status
		& (monitor_priority < current_priority)
		& ((SECURITY_EXT == 0) | ~fetch_secure
		| secure_monitor_enable);

	assign bkpt_halt    = bkpt_match & halt_ok;
	assign bkpt_monitor = bkpt_match & ~halt_ok & mon_ok;
	assign bkpt_discard = bkpt_match & ~halt_ok & ~mon_ok;

	// Record of the latest breakpoint and its outcome
	always @* begin
		last_bkpt_valid_next  = last_bkpt_valid_reg;
		last_bkpt_addr_next   = last_bkpt_addr_reg;
		last_bkpt_result_next = last_bkpt_result_reg;
		if (bkpt_match) begin
			last_bkpt_valid_next = 1'b1;
			last_bkpt_addr_next  = fetch_addr;
			if (bkpt_halt) begin
				last_bkpt_result_next = RES_HALT;
			end else if (bkpt_monitor) begin
				last_bkpt_result_next = RES_MONITOR;
			end else begin
				last_bkpt_result_next = RES_DISCARD;
			end
		end
	end

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			last_bkpt_valid_reg  <= 1'b0;
			last_bkpt_addr_reg   <= 32'h0000_0000;
			last_bkpt_result_reg <= 3'h0;
		end else begin
			last_bkpt_valid_reg  <= last_bkpt_valid_next;
			last_bkpt_addr_reg   <= last_bkpt_addr_next;
			last_bkpt_result_reg <= last_bkpt_result_next;
		end
	end

	always @* begin
		code_rd_addr   = 32'h0000_0000;
		code_rd_enable = 1'b0;
		code_rd_remap  = 1'b0;
		code_rd_both   = 1'b0;
		for (k = 0; k < NUM_CODE; k = k + 1) begin
			if (code_rd_idx == k) begin
				code_rd_addr   = code_addr_all[k*32 +: 32];
				code_rd_enable = code_en_all[k];
				code_rd_remap  = code_remap_all[k];
				code_rd_both   = code_both_all[k];
			end
		end
	end

	always @* begin
		lit_rd_addr   = 32'h0000_0000;
		lit_rd_enable = 1'b0;
		for (m = 0; m < LITERAL_COMPARATOR_COUNT; m = m + 1) begin
			if (lit_rd_idx == m) begin
				lit_rd_addr   = lit_addr_all[m*32 +: 32];
				lit_rd_enable = lit_en_all[m];
			end
		end
	end

endmodule // pbu_match

// file: logic/pbu_consts.vh
`ifndef PBU_CONSTS_VH
`define PBU_CONSTS_VH

// Code memory region: top address bits equal to this tag
`define PBU_CODE_HI        31
`define PBU_CODE_LO        29
`define PBU_CODE_TAG       3'h0

// Remap base field starts at this address bit
`define PBU_REMAP_LSB      5
`define PBU_REMAP_W        27
`define PBU_REMAP_RST      27'h000_0000
`define PBU_GLOBAL_EN_RST  1'h0

// Comparator reset values
`define PBU_CMP_EN_RST     1'h0
`define PBU_CMP_REMAP_RST  1'h0
`define PBU_CMP_BOTH_RST   1'h0
`define PBU_CODE_ADDR_RST  31'h0000_0000
`define PBU_LIT_ADDR_RST   30'h0000_0000

// Widths of count fields, comparator index and slot number
`define PBU_CNT_W          4
`define PBU_IDX_W          4
`define PBU_SLOT_W         5

// Read size encoding
`define PBU_SIZE_BYTE      2'h0
`define PBU_SIZE_HALF      2'h1
`define PBU_SIZE_WORD      2'h2

`endif

// file: logic/pbu_code_cmp.v
`timescale 1ns/10ps
`include "pbu_consts.vh"

module pbu_code_cmp #(
	parameter REMAP_OK = 1
) (
	input  wire        clk,
	input  wire        rstn,
	input  wire        cfg_wr,
	input  wire [31:0] cfg_addr,
	input  wire        cfg_enable,
	input  wire        cfg_remap,
	input  wire        cfg_both,
	input  wire        global_enable,
	input  wire        fetch_valid,
	input  wire [31:0] fetch_addr,
	output wire        bp_hit,
	output wire        remap_hit,
	output wire [31:0] cmp_addr,
	output wire        cmp_enable,
	output wire        cmp_remap,
	output wire        cmp_both
);

	reg  [30:0] addr_reg;
	reg         enable_reg;
	reg         remap_reg;
	reg         both_reg;
	wire        active;
	wire        in_code;
	wire        bp_eq;
	wire        word_eq;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			addr_reg   <= `PBU_CODE_ADDR_RST;
			enable_reg <= `PBU_CMP_EN_RST;
			remap_reg  <= `PBU_CMP_REMAP_RST;
			both_reg   <= `PBU_CMP_BOTH_RST;
		end else if (cfg_wr) begin
			addr_reg   <= cfg_addr[31:1];
			enable_reg <= cfg_enable;
			remap_reg  <= cfg_remap & (REMAP_OK != 0);
			both_reg   <= cfg_both;
		end
	end

	assign active  = enable_reg & global_enable;
	assign in_code = fetch_addr[`PBU_CODE_HI:`PBU_CODE_LO] == `PBU_CODE_TAG;
	assign word_eq = fetch_addr[31:2] == addr_reg[30:1];
	// Halfword match, or both halves of a 32-bit instruction
	assign bp_eq   = both_reg ? word_eq
		: (fetch_addr[31:1] == addr_reg);

	assign bp_hit    = active & ~remap_reg & fetch_valid & bp_eq;
	assign remap_hit = active & remap_reg & fetch_valid & in_code
		& word_eq;

	assign cmp_addr   = {addr_reg, 1'b0};
	assign cmp_enable = enable_reg;
	assign cmp_remap  = remap_reg;
	assign cmp_both   = both_reg;

endmodule // pbu_code_cmp

// file: logic/pbu_lit_cmp.v
`timescale 1ns/10ps
`include "pbu_consts.vh"

module pbu_lit_cmp (
	input  wire        clk,
	input  wire        rstn,
	input  wire        cfg_wr,
	input  wire [31:0] cfg_addr,
	input  wire        cfg_enable,
	input  wire        global_enable,
	input  wire        rd_valid,
	input  wire [31:0] rd_addr,
	output wire        hit,
	output wire [31:0] cmp_addr,
	output wire        cmp_enable
);

	reg  [29:0] addr_reg;
	reg         enable_reg;
	wire        in_code;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			addr_reg   <= `PBU_LIT_ADDR_RST;
			enable_reg <= `PBU_CMP_EN_RST;
		end else if (cfg_wr) begin
			addr_reg   <= cfg_addr[31:2];
			enable_reg <= cfg_enable;
		end
	end

	assign in_code = rd_addr[`PBU_CODE_HI:`PBU_CODE_LO] == `PBU_CODE_TAG;
	// Low two bits ignored: any byte of the word matches
	assign hit = enable_reg & global_enable & rd_valid & in_code
		& (rd_addr[31:2] == addr_reg);

	assign cmp_addr   = {addr_reg, 2'b00};
	assign cmp_enable = enable_reg;

endmodule // pbu_lit_cmp

// file: verif/pbu_match_checker.sv
`timescale 1ns/10ps
module pbu_match_checker (
	input wire        clk,
	input wire        rstn,
	input wire        global_enable,
	input wire [31:0] remap_base,
	input wire        fetch_valid,
	input wire [31:0] fetch_addr,
	input wire        fetch_from_dap,
	input wire        fetch_redirect,
	input wire [31:0] fetch_addr_out,
	input wire [31:0] fetch_pc_value,
	input wire        bkpt_match,
	input wire        bkpt_halt,
	input wire        bkpt_monitor,
	input wire        bkpt_discard,
	input wire        halting_auth_allowed,
	input wire        halting_debug_enable,
	input wire        halted_status,
	input wire        data_valid,
	input wire [31:0] data_addr,
	input wire        data_write,
	input wire        data_redirect,
	input wire [31:0] data_check_addr,
	input wire        last_bkpt_valid_reg,
	input wire [31:0] last_bkpt_addr_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_hit;
		fetch_valid && bkpt_match;
	endsequence
	sequence s_logged;
		last_bkpt_valid_reg && last_bkpt_addr_reg == $past(fetch_addr);
	endsequence
	a_bkpt_record_kept: assert property (s_hit |=> s_logged)
		else $error("breakpoint record not updated");
	a_dap_never_hits: assert property (fetch_from_dap |->
		!fetch_redirect && !bkpt_match) else $error("debug port fetch hit");
	a_pc_from_origin: assert property (fetch_valid |->
		fetch_pc_value == fetch_addr) else $error("pc value not original");
	a_check_on_origin: assert property (data_valid |->
		data_check_addr == data_addr) else $error("check address moved");
	a_write_passes: assert property (data_write |->
		!data_redirect) else $error("data write redirected");
	a_single_outcome: assert property (bkpt_match |->
		$onehot({bkpt_halt, bkpt_monitor, bkpt_discard}))
		else $error("breakpoint outcome not single");
	a_halt_when_allowed: assert property (bkpt_match
		&& halting_auth_allowed && halting_debug_enable && !halted_status
		|-> bkpt_halt) else $error("allowed halt missing");
	a_global_gates: assert property (!global_enable |-> !fetch_redirect
		&& !bkpt_match && !data_redirect) else $error("match while off");
	a_redirect_base: assert property (fetch_redirect |->
		fetch_addr_out[31:5] == remap_base[31:5] &&
		fetch_addr_out[1:0] == fetch_addr[1:0]) else $error("bad slot");
	a_remap_code_only: assert property (fetch_redirect |->
		fetch_addr[31:29] == 3'h0) else $error("remap outside code");
endmodule // pbu_match_checker

bind pbu_match pbu_match_checker chk_u (.clk, .rstn, .global_enable,
	.remap_base, .fetch_valid, .fetch_addr, .fetch_from_dap, .fetch_redirect,
	.fetch_addr_out, .fetch_pc_value, .bkpt_match, .bkpt_halt, .bkpt_monitor,
	.bkpt_discard, .halting_auth_allowed, .halting_debug_enable,
	.halted_status, .data_valid, .data_addr, .data_write, .data_redirect,
	.data_check_addr, .last_bkpt_valid_reg, .last_bkpt_addr_reg);

// file: verif/pbu_core_model.sv
`timescale 1ns/10ps
module pbu_core_model (
	input  wire        clk,
	output reg         fetch_valid,
	output reg  [31:0] fetch_addr,
	output reg         fetch_from_dap,
	output reg         fetch_secure,
	output reg         data_valid,
	output reg  [31:0] data_addr,
	output reg         data_write,
	output reg  [1:0]  data_size,
	output reg         data_stacking,
	output reg         data_vector,
	output reg         data_from_dap
);
	initial begin
		{fetch_valid, fetch_addr, fetch_from_dap, fetch_secure} = 0;
		{data_valid, data_addr, data_write, data_size} = 0;
		{data_stacking, data_vector, data_from_dap} = 0;
	end
	task fetch(input [31:0] a, input debug_access_port);
		@(posedge clk);
		fetch_valid <= 1;
		fetch_addr <= a;
		fetch_from_dap <= debug_access_port;
		fetch_secure <= ~fetch_secure;
		data_valid <= 0;
	endtask
	// Kind bits: write, debug port, vector read, hardware stacking
	task read(input [31:0] a, input [1:0] sz, input [3:0] kd);
		@(posedge clk);
		data_valid <= 1;
		data_addr <= a;
		data_size <= sz;
		{data_write, data_from_dap, data_vector, data_stacking} <=
			kd;
		fetch_valid <= 0;
	endtask
	// Released address lines show the inverted last value, not the last value
	task rest;
		@(posedge clk);
		fetch_valid <= 0;
		data_valid <= 0;
		fetch_addr <= ~fetch_addr;
		data_addr <= ~data_addr;
	endtask
endmodule // pbu_core_model

// file: verif/pbu_match_bench.sv
`timescale 1ns/10ps
module pbu_match_bench;
	logic clk = 0, rstn = 0, ctrl_wr = 0, ctrl_enable = 0, remap_wr = 0;
	logic code_cfg_wr = 0, code_cfg_enable = 0, code_cfg_remap = 0;
	logic code_cfg_both = 0, lit_cfg_wr = 0, lit_cfg_enable = 0;
	logic halting_auth_allowed = 0, halting_debug_enable = 0;
	logic halted_status = 0, secure_debug_flag = 0, monitor_enable = 0;
	logic secure_monitor_enable = 0;
	logic [31:0] remap_base_in = 0, code_cfg_addr = 0, lit_cfg_addr = 0;
	logic [3:0] code_cfg_idx = 0, lit_cfg_idx = 0;
	logic [3:0] code_rd_idx = 0, lit_rd_idx = 0;
	logic [7:0] monitor_priority = 0, current_priority = 0;
	wire fetch_valid, fetch_from_dap, fetch_secure, data_valid, data_write;
	wire data_stacking, data_vector, data_from_dap, global_enable;
	wire remap_supported_flag, code_rd_enable, code_rd_remap, code_rd_both;
	wire lit_rd_enable, fetch_redirect, bkpt_match, bkpt_halt, bkpt_monitor;
	wire bkpt_discard, data_redirect, last_bkpt_valid_reg;
	wire [1:0] data_size;
	wire [2:0] last_bkpt_result_reg;
	wire [3:0] code_comparator_count, literal_comparator_count;
	wire [31:0] fetch_addr, data_addr, remap_base, code_rd_addr, lit_rd_addr;
	wire [31:0] fetch_addr_out, fetch_pc_value, data_addr_out;
	wire [31:0] data_check_addr, last_bkpt_addr_reg;
	logic [31:0] m_ca[16] = '{default: 0}, m_la[16] = '{default: 0};
	logic [15:0] m_ce = 0, m_cr = 0, m_cb = 0, m_le = 0;
	logic [31:0] m_base = 0, bpa;
	logic m_ge = 0;
	int n_mismatch = 0, checks_done = 0;

	pbu_match dut_u (.*);
	pbu_core_model core_u (.*);

	always #5 clk = ~clk;

	task report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task cmp(input [39:0] e, input [39:0] a);
		checks_done++;
		if (a !== e) begin
			n_mismatch++;
			$display("ERROR %0t expected %h got %h", $time, e, a);
		end
	endtask
	function logic bp_hit(input [31:0] a);
		bp_hit = 0;
		for (int k = 0; k < 6; k++)
			if (m_ge && m_ce[k] && !m_cr[k] && (m_cb[k] ?
			    a[31:2] == m_ca[k][31:2] : a[31:1] == m_ca[k][31:1]))
				bp_hit = 1;
	endfunction
	function logic [32:0] slot(input int n, input [1:0] lo);
		slot = {1'b1, (m_base + 32'(4 * n)) | {30'h0, lo}};
	endfunction
	function logic [32:0] f_exp(input [31:0] a);
		f_exp = {1'b0, a};
		for (int k = 5; k >= 0; k--)
			if (m_ge && m_ce[k] && m_cr[k] && a[31:29] == 0 &&
			    a[31:2] == m_ca[k][31:2])
				f_exp = slot(k, a[1:0]);
		if (bp_hit(a))
			f_exp = {1'b0, a};
	endfunction
	function logic [32:0] d_exp(input [31:0] a, input [1:0] s, input [3:0] kd);
		d_exp = {1'b0, a};
		for (int k = 1; k >= 0; k--)
			if (m_ge && m_le[k] && kd[3:2] == 0 && a[31:29] == 0 &&
			    a[31:2] == m_la[k][31:2] &&
			    (s == 0 || (s == 1 && !a[0]) || a[1:0] == 0))
				d_exp = slot(6 + k, a[1:0]);
	endfunction
	function logic [2:0] o_exp();
		if (halting_auth_allowed && halting_debug_enable && !halted_status)
			return 3'h1;
		if (monitor_enable && halted_status &&
		    monitor_priority < current_priority)
			return 3'h2;
		return 3'h4;
	endfunction
	task cfg_code(input int k, input [31:0] a, input en, rm, b);
		@(posedge clk);
		{code_cfg_wr, code_cfg_idx, code_cfg_addr} <= {1'b1, k[3:0], a};
		{code_cfg_enable, code_cfg_remap, code_cfg_both} <= {en, rm, b};
		code_rd_idx <= k[3:0];
		if (k < 6) begin
			m_ca[k] = {a[31:1], 1'b0};
			{m_ce[k], m_cr[k], m_cb[k]} = {en, rm, b};
		end
		@(posedge clk);
		code_cfg_wr <= 0;
		@(negedge clk);
		cmp({m_cb[k], m_ce[k], m_cr[k], m_ca[k]},
		    {code_rd_both, code_rd_enable, code_rd_remap, code_rd_addr});
	endtask
	task cfg_lit(input int k, input [31:0] a, input en);
		@(posedge clk);
		{lit_cfg_wr, lit_cfg_idx, lit_cfg_addr} <= {1'b1, k[3:0], a};
		{lit_cfg_enable, lit_rd_idx} <= {en, k[3:0]};
		if (k < 2)
			{m_le[k], m_la[k]} = {en, a[31:2], 2'h0};
		@(posedge clk);
		lit_cfg_wr <= 0;
		@(negedge clk);
		cmp({m_le[k], m_la[k]}, {lit_rd_enable, lit_rd_addr});
	endtask
	task cfg_ctrl(input en, input [31:0] b);
		@(posedge clk);
		{ctrl_wr, ctrl_enable, remap_wr, remap_base_in} <= {1'b1, en, 1'b1, b};
		{m_ge, m_base} = {en, b[31:5], 5'h0};
		@(posedge clk);
		{ctrl_wr, remap_wr} <= 0;
		@(negedge clk);
		cmp({m_ge, m_base}, {global_enable, remap_base});
	endtask
	task fch(input [31:0] a, input debug_access_port);
		logic b;
		core_u.fetch(a, debug_access_port);
		@(negedge clk);
		b = !debug_access_port && bp_hit(a);
		cmp({b, debug_access_port ? {1'b0, a} : f_exp(a)},
		    {bkpt_match, fetch_redirect, fetch_addr_out});
		if (b)
			cmp(o_exp(), {bkpt_discard, bkpt_monitor, bkpt_halt});
	endtask
	task rd(input [31:0] a, input [1:0] s, input [3:0] kd);
		core_u.read(a, s, kd);
		@(negedge clk);
		cmp(d_exp(a, s, kd), {data_redirect, data_addr_out});
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		report_and_stop;
	end
	initial begin
		void'($urandom(61));
		repeat (5) @(posedge clk);
		rstn <= 1;
		@(negedge clk);
		cmp({m_ge, m_base}, {global_enable, remap_base});
		cmp({9'h162}, {remap_supported_flag, code_comparator_count,
		    literal_comparator_count});
		bpa = $urandom & 32'hffff_fffe;
		cfg_code(0, 32'h0000_0100, 1, 1, 0);
		cfg_code(1, bpa, 1, 0, 0);
		cfg_code(2, 32'h0000_0402, 1, 0, 1);
		cfg_code(6, 32'h0000_0300, 1, 1, 0);
		cfg_lit(0, 32'h0000_0200, 1);
		cfg_lit(1, $urandom & 32'h1fff_fffc, 1);
		fch(32'h0000_0102, 0);
		cfg_ctrl(1, 32'h2000_0000);
		fch(32'h0000_0102, 0);
		fch(32'h0000_0100, 1);
		cfg_code(3, 32'h2000_0100, 1, 1, 0);
		fch(32'h2000_0100, 0);
		fch(32'h0000_0200, 0);
		fch(32'h0000_0400, 0);
		rd(32'h0000_0100, 2, 0);
		for (int s = 0; s < 3; s++)
			rd(32'h0000_0200 + 3 - s - (s == 2), s[1:0], 0);
		rd(32'h0000_0201, 2, 0);
		cfg_lit(1, 32'h2000_0204, 1);
		rd(32'h2000_0204, 2, 0);
		for (int kd = 0; kd < 4; kd++)
			rd(32'h0000_0200, 2, 4'h1 << kd);
		repeat (24) begin
			@(posedge clk);
			{halting_auth_allowed, halting_debug_enable, halted_status,
			 monitor_enable, secure_debug_flag, secure_monitor_enable,
			 monitor_priority, current_priority} <= 22'($urandom);
			fch(bpa, 0);
			core_u.rest;
			@(negedge clk);
			cmp({1'b1, bpa, o_exp()}, {last_bkpt_valid_reg,
			    last_bkpt_addr_reg, last_bkpt_result_reg});
		end
		cfg_code(0, 32'h0000_0100, 0, 1, 0);
		fch(32'h0000_0102, 0);
		@(posedge clk);
		rstn <= 0;
		repeat (2) @(posedge clk);
		rstn <= 1;
		{m_ge, m_base, m_ce, m_cr, m_cb, m_le} = 0;
		@(negedge clk);
		cmp({m_ge, m_base}, {global_enable, remap_base});
		fch(32'h0000_0102, 0);
		cfg_ctrl(1, 32'h2000_0000);
		fch(bpa, 0);
		core_u.rest;
		report_and_stop;
	end
endmodule // pbu_match_bench
